/* File: inc/stack_call_pkg.sv */
// Package for the push / relative-call / software-reset executor.
// Assumes a 16-bit instruction word and a 21-bit byte program counter.
package stack_call_pkg;
    localparam int ADDR_WIDTH = 21;
    localparam int INSTR_WIDTH = 16;
    localparam logic [15:0] OPC_PUSH = 16'h0005;
    localparam logic [15:0] OPC_SOFT_RESET = 16'h00ff;
    localparam logic [4:0] OPC_CALL_TOP = 5'h1b;
    localparam logic [ADDR_WIDTH-1:0] ADDR_STEP = 21'h000002;
    localparam logic [ADDR_WIDTH-1:0] ADDR_RESET_VALUE = 21'h000000;
    localparam int CALL_CYCLES = 2;
    localparam int SINGLE_CYCLES = 1;

    // Quarter phases, Gray coded along the cycle
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b11,
        PH_WRITE = 2'b10
    } phase_t;

    typedef struct packed {
        logic push;
        logic [ADDR_WIDTH-1:0] value;
    } stack_push_t;
endpackage : stack_call_pkg

/* File: logic/stack_call_exec.sv */
// Executes push, relative call and software reset on the program counter and stack.
// Assumes instr holds for a whole instruction cycle; deeper stack levels live outside.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - The push opcode 0x0005 places program counter plus two on top of the stack.
// - A push moves the old top entry one level deeper, preserving it.
// - Push is one word and completes in one instruction cycle.
// - Relative call is top bits 11011 with an 11-bit two's-complement word offset.
// - Relative call first pushes program counter plus two as the return address.
// - Relative call loads program counter plus two plus twice the offset.
// - Relative call takes two cycles, the second doing nothing.
// - The 0x00ff opcode restores the state a master clear produces.
// - Software reset is single cycle, starting reset in the second phase.
module stack_call_exec
    import stack_call_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [INSTR_WIDTH-1:0] instr,
    output logic [ADDR_WIDTH-1:0] program_counter,
    output logic [ADDR_WIDTH-1:0] top_of_stack,
    output logic [ADDR_WIDTH-1:0] stack_below,
    output logic [1:0] phase,
    output logic instr_done,
    output logic idle_cycle,
    output logic master_clear_req
);

    ////////////////////////////////////////////////////////////////
    // Decoder and datapath state
    phase_t phase_reg;
    phase_t phase_next;
    logic [ADDR_WIDTH-1:0] prog_reg;
    logic [ADDR_WIDTH-1:0] prog_next;
    logic [ADDR_WIDTH-1:0] top_reg;
    logic [ADDR_WIDTH-1:0] top_next;
    logic [ADDR_WIDTH-1:0] below_reg;
    logic [ADDR_WIDTH-1:0] below_next;
    logic idle_reg;
    logic idle_next;
    logic done_reg;
    logic done_next;
    logic clr_reg;
    logic clr_next;
    logic is_push;
    logic is_call;
    logic is_reset;
    logic [ADDR_WIDTH-1:0] prog_plus2;
    logic [ADDR_WIDTH-1:0] disp2;
    stack_push_t sp;

    // Opcode matches
    assign is_push = (instr == OPC_PUSH);
    assign is_call = (instr[15:11] == OPC_CALL_TOP);
    assign is_reset = (instr == OPC_SOFT_RESET);

    // Return address and doubled, sign-extended word offset
    assign prog_plus2 = prog_reg + ADDR_STEP;
    assign disp2 = {{(ADDR_WIDTH-12){instr[10]}}, instr[10:0], 1'b0};

    always_comb begin
        phase_next = phase_reg;
        prog_next = prog_reg;
        top_next = top_reg;
        below_next = below_reg;
        idle_next = idle_reg;
        done_next = 1'b0;
        clr_next = 1'b0;
        sp = '{push: 1'b0, value: prog_plus2};
        case (phase_reg)
            PH_DECODE: phase_next = PH_READ;
            PH_READ: begin
                phase_next = PH_PROCESS;
                if (!idle_reg && (is_push || is_call)) begin
                    sp.push = 1'b1;
                end
                if (!idle_reg && is_reset) begin
                    clr_next = 1'b1;
                end
            end
            PH_PROCESS: phase_next = PH_WRITE;
            PH_WRITE: begin
                phase_next = PH_DECODE;
                done_next = 1'b1;
                if (idle_reg) begin
                    idle_next = 1'b0;
                    prog_next = prog_reg;
                end else if (is_call) begin
                    prog_next = prog_plus2 + disp2;
                    idle_next = 1'b1;
                end else begin
                    prog_next = prog_plus2;
                end
            end
            default: phase_next = PH_DECODE;
        endcase
        if (sp.push) begin
            below_next = top_reg;
            top_next = sp.value;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || clr_reg) begin
            phase_reg <= PH_DECODE;
            prog_reg <= ADDR_RESET_VALUE;
            top_reg <= ADDR_RESET_VALUE;
            below_reg <= ADDR_RESET_VALUE;
            idle_reg <= 1'b0;
            done_reg <= 1'b0;
            clr_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            prog_reg <= prog_next;
            top_reg <= top_next;
            below_reg <= below_next;
            idle_reg <= idle_next;
            done_reg <= done_next;
            clr_reg <= clr_next;
        end
    end

    // Outputs straight from the registers
    assign program_counter = prog_reg;
    assign top_of_stack = top_reg;
    assign stack_below = below_reg;
    assign phase = phase_reg;
    assign instr_done = done_reg;
    assign idle_cycle = idle_reg;
    assign master_clear_req = clr_reg;

    ////////////////////////////////////////////////////////////////
    // Check helper: instruction cycles already spent on the current instruction
    logic [1:0] span_reg;
    logic [1:0] span_next;

    always_comb begin
        span_next = span_reg;
        if (phase_reg == PH_WRITE) begin
            if (!idle_reg && is_call) begin
                span_next = 2'h1;
            end else begin
                span_next = 2'h0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || clr_reg) begin
            span_reg <= 2'h0;
        end else begin
            span_reg <= span_next;
        end
    end

    // Byte displacement worked out apart from the datapath
    logic [ADDR_WIDTH-1:0] chk_disp;
    assign chk_disp = ADDR_WIDTH'(signed'({instr[10:0], 1'b0}));

    ////////////////////////////////////////////////////////////////
    // Checks
    sequence s_push_phase;
        phase_reg == PH_READ && !idle_reg && is_push;
    endsequence

    sequence s_call_read;
        phase_reg == PH_READ && !idle_reg && is_call;
    endsequence

    sequence s_call_write;
        phase_reg == PH_WRITE && !idle_reg && is_call;
    endsequence

    // Four quarter phases of the no-operation cycle, then back to work
    sequence s_idle_run;
        idle_reg [*4] ##1 !idle_reg;
    endsequence

    sequence s_phase_walk;
        phase_reg == PH_READ ##1 phase_reg == PH_PROCESS ##1 phase_reg == PH_WRITE;
    endsequence

    a_push_top_value: assert property (@(posedge clock) disable iff (!nrst)
        s_push_phase |=> top_reg == $past(prog_reg) + ADDR_STEP)
        else $error("push did not load counter plus two");
    a_other_no_push: assert property (@(posedge clock) disable iff (!nrst)
        phase_reg == PH_READ && (idle_reg || !(is_push || is_call)) |=> $stable(top_reg)
        && $stable(below_reg))
        else $error("stack changed without a push");
    a_push_keeps_old: assert property (@(posedge clock) disable iff (!nrst)
        s_push_phase |=> below_reg == $past(top_reg))
        else $error("old top not moved down");
    a_call_keeps_old: assert property (@(posedge clock) disable iff (!nrst)
        s_call_read |=> below_reg == $past(top_reg))
        else $error("old top not moved down by call");
    a_push_one_cycle: assert property (@(posedge clock) disable iff (!nrst)
        s_push_phase ##2 1'b1 |=> !idle_reg && prog_reg == $past(prog_reg, 3) + ADDR_STEP)
        else $error("push not single cycle");
    a_push_span: assert property (@(posedge clock) disable iff (!nrst)
        phase_reg == PH_WRITE && !idle_reg && is_push |-> span_reg == 2'(SINGLE_CYCLES - 1))
        else $error("push used more than one cycle");
    a_call_return_addr: assert property (@(posedge clock) disable iff (!nrst)
        s_call_read |=> top_reg == $past(prog_reg) + ADDR_STEP)
        else $error("call return address wrong");
    a_call_target: assert property (@(posedge clock) disable iff (!nrst || clr_reg)
        s_call_write |=> prog_reg == $past(prog_reg) + ADDR_STEP + $past(chk_disp))
        else $error("call target wrong");
    a_call_idle_cycle: assert property (@(posedge clock) disable iff (!nrst || clr_reg)
        s_call_write |=> s_idle_run)
        else $error("call idle cycle missing");
    a_call_span: assert property (@(posedge clock) disable iff (!nrst)
        phase_reg == PH_WRITE && idle_reg |-> span_reg == 2'(CALL_CYCLES - 1))
        else $error("idle cycle not second cycle of a call");
    a_idle_holds_state: assert property (@(posedge clock) disable iff (!nrst || clr_reg)
        idle_reg |=> top_reg == $past(top_reg) && below_reg == $past(below_reg)
        && prog_reg == $past(prog_reg))
        else $error("idle cycle changed state");
    a_reset_restore: assert property (@(posedge clock) disable iff (!nrst)
        clr_reg |=> prog_reg == ADDR_RESET_VALUE && top_reg == ADDR_RESET_VALUE)
        else $error("software reset did not clear state");
    a_reset_all_regs: assert property (@(posedge clock) disable iff (!nrst)
        clr_reg |=> below_reg == ADDR_RESET_VALUE && !idle_reg && !done_reg)
        else $error("software reset left state behind");
    a_reset_phase_two: assert property (@(posedge clock) disable iff (!nrst)
        $rose(clr_reg) |-> $past(phase_reg) == PH_READ && $past(is_reset))
        else $error("reset not started in second phase");
    a_clear_one_pulse: assert property (@(posedge clock) disable iff (!nrst)
        clr_reg |=> !clr_reg && phase_reg == PH_DECODE)
        else $error("clear request longer than one edge");
    a_phase_order: assert property (@(posedge clock) disable iff (!nrst || clr_reg)
        phase_reg == PH_DECODE |=> s_phase_walk)
        else $error("quarter phases out of order");
    a_done_after_write: assert property (@(posedge clock) disable iff (!nrst)
        phase_reg == PH_WRITE |=> done_reg && phase_reg == PH_DECODE)
        else $error("cycle end not flagged");
endmodule : stack_call_exec
`default_nettype wire

/* File: sim/stack_call_reset_instructions_tb.sv */
// Self-checking bench for the push, relative call and software reset executor.
// Assumes the executor alone; the bench drives instr at falling edges.
`timescale 1ns/100ps
`default_nettype none
module stack_call_reset_instructions_tb;
    import stack_call_pkg::*;
    logic clock, nrst, instr_done, idle_cycle, master_clear_req;
    logic [INSTR_WIDTH-1:0] instr;
    logic [ADDR_WIDTH-1:0] program_counter, top_of_stack, stack_below;
    logic [ADDR_WIDTH-1:0] prog_exp, top_exp, below_exp;
    logic [1:0] phase;
    int fails = 0;
    int check_count = 0;
    stack_call_exec dut (.clock(clock), .nrst(nrst), .instr(instr),
        .program_counter(program_counter), .top_of_stack(top_of_stack),
        .stack_below(stack_below), .phase(phase), .instr_done(instr_done),
        .idle_cycle(idle_cycle), .master_clear_req(master_clear_req));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    // Waits for a decode phase outside an idle cycle, then presents op
    task automatic start_op(input logic [15:0] op);
        int n;
        n = 0;
        while ((phase !== PH_DECODE || idle_cycle !== 1'b0) && n < 8) begin
            @(negedge clock);
            n++;
        end
        if (phase !== PH_DECODE || idle_cycle !== 1'b0) begin
            fails++;
            stop_test();
        end else begin
            instr = op;
        end
    endtask : start_op
    task automatic exec_op(input logic [15:0] op, input logic is_call);
        start_op(op);
        repeat (4) @(negedge clock);
        chk("program_counter", prog_exp, program_counter);
        chk("top_of_stack", top_exp, top_of_stack);
        chk("stack_below", below_exp, stack_below);
        chk("instr_done", 1, instr_done);
        chk("idle_cycle", is_call, idle_cycle);
        if (is_call) begin
            repeat (4) @(negedge clock);
            chk("idle_cycle", 0, idle_cycle);
            chk("program_counter", prog_exp, program_counter);
            chk("top_of_stack", top_exp, top_of_stack);
        end
    endtask : exec_op
    ////////////////////////////////////////////////////////////////
    task automatic push_test();
        repeat (2) begin
            below_exp = top_exp;
            top_exp = prog_exp + ADDR_STEP;
            prog_exp = prog_exp + ADDR_STEP;
            exec_op(OPC_PUSH, 1'b0);
        end
        $display("push test done");
    endtask : push_test
    task automatic other_test();
        prog_exp = prog_exp + ADDR_STEP;
        exec_op(16'h0000, 1'b0);
        $display("other opcode test done");
    endtask : other_test
    task automatic call_test(input logic [10:0] n);
        below_exp = top_exp;
        top_exp = prog_exp + ADDR_STEP;
        prog_exp = prog_exp + ADDR_STEP + {{9{n[10]}}, n, 1'b0};
        exec_op({OPC_CALL_TOP, n}, 1'b1);
        $display("call test done, offset %h", n);
    endtask : call_test
    task automatic reset_test();
        start_op(OPC_SOFT_RESET);
        repeat (2) @(negedge clock);
        chk("master_clear_req", 1, master_clear_req);
        @(negedge clock);
        instr = 16'h0000;
        chk("program_counter", 0, program_counter);
        chk("top_of_stack", 0, top_of_stack);
        chk("stack_below", 0, stack_below);
        chk("phase", PH_DECODE, phase);
        $display("software reset test done");
    endtask : reset_test
    initial begin
        nrst = 1'b0;
        instr = 16'h0000;
        prog_exp = ADDR_RESET_VALUE;
        top_exp = ADDR_RESET_VALUE;
        below_exp = ADDR_RESET_VALUE;
        repeat (2) @(negedge clock);
        chk("program_counter", prog_exp, program_counter);
        chk("phase", PH_DECODE, phase);
        nrst = 1'b1;
        push_test();
        other_test();
        call_test(11'h7ff);
        call_test(11'h3ff);
        call_test(11'h400);
        reset_test();
        stop_test();
    end
endmodule : stack_call_reset_instructions_tb
`default_nettype wire
